//--- mdss_spi_slave.sv
////////////////////////////////////////////////////////////////////////////////
// Purpose: SPI slave port that turns frames into register writes and reads
// Assumes: SCLK, MOSI and select arrive from the master's clock domain
// Notes:   Responses to a frame travel during the following frame
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Buffer of pending register writes
module mdss_fifo #(
  parameter int unsigned WIDTH = 48,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [PW:0]      cnt_q, cnt_d;
  logic             push, pop;

  // Pointer and level update; full and empty come from the level
  always_comb begin
    push = in_valid && in_ready;
    pop  = out_valid && out_ready;
    wr_d = push ? PW'(wr_q + 1'b1) : wr_q;
    rd_d = pop ? PW'(rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = (PW+1)'(cnt_q + 1'b1);
    end else if (pop && !push) begin
      cnt_d = (PW+1)'(cnt_q - 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q      <= '0;
      rd_q      <= '0;
      cnt_q     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      wr_q      <= wr_d;
      rd_q      <= rd_d;
      cnt_q     <= cnt_d;
      in_ready  <= (cnt_d != (PW+1)'(DEPTH));
      out_valid <= (cnt_d != '0);
    end
  end

  // Storage has no reset
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  assign out_data = mem_q[rd_q];
endmodule

////////////////////////////////////////////////////////////////////////////////
// Top: SPI frame engine
module mdss_spi_slave (
  input  wire logic        CORE_CLK,
  input  wire logic        RSTN,
  input  wire logic        SPI_SCLK,
  input  wire logic        SPI_MOSI,
  input  wire logic        SPI_SS_N,
  output logic             SPI_MISO,
  output logic             FRAME_PENDING_OUT,
  output logic             WR_VALID,
  input  wire logic        WR_READY,
  output logic [15:0]      WR_ADDR,
  output logic [31:0]      WR_DATA,
  output logic             RD_REQ,
  output logic [15:0]      RD_ADDR,
  input  wire logic        RD_ACK,
  input  wire logic        RD_FAIL,
  input  wire logic [31:0] RD_DATA,
  input  wire logic [31:0] PTR0_DATA,
  input  wire logic        PTR0_FAIL,
  input  wire logic [31:0] PTR1_DATA,
  input  wire logic        PTR1_FAIL
);
  localparam int unsigned CNT_W    = mdss_pkg::CNT_W;
  localparam int unsigned BITCNT_W = mdss_pkg::BITCNT_W;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, two stages, then one history stage for edges
  logic [2:0] sclk_q, sclk_d, ss_q, ss_d;
  logic [1:0] mosi_q, mosi_d;
  logic       sclk_rise, sclk_fall, ss_fall, ss_rise;

  always_comb begin
    sclk_d = {sclk_q[1:0], SPI_SCLK};
    ss_d   = {ss_q[1:0], SPI_SS_N};
    mosi_d = {mosi_q[0], SPI_MOSI};
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sclk_q <= 3'h0;
      ss_q   <= 3'h7;
      mosi_q <= 2'h0;
    end else begin
      sclk_q <= sclk_d;
      ss_q   <= ss_d;
      mosi_q <= mosi_d;
    end
  end

  // Edges seen on synchronised stages only; mode 1 idles low
  assign sclk_rise = sclk_q[1] && !sclk_q[2];
  assign sclk_fall = !sclk_q[1] && sclk_q[2];
  assign ss_fall   = !ss_q[1] && ss_q[2];
  assign ss_rise   = ss_q[1] && !ss_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // 10 kHz register update tick
  logic [CNT_W-1:0] tick_q, tick_d;
  logic             tick;

  always_comb begin
    tick   = (tick_q == CNT_W'(mdss_pkg::UPDATE_CYCLES - 1));
    tick_d = tick ? '0 : CNT_W'(tick_q + 1'b1);
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      tick_q <= '0;
    end else begin
      tick_q <= tick_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame control state
  mdss_pkg::mdss_state_type st_q, st_d;
  logic [BITCNT_W-1:0] bitcnt_q, bitcnt_d;
  logic             pend_q, pend_d, is_wr_q, is_wr_d, is_rd_q, is_rd_d;
  logic             ok0_q, ok0_d, ok1_q, ok1_d, rdreq_q, rdreq_d;
  logic [CNT_W-1:0] wait_q, wait_d;
  logic [31:0]      rdres_q, rdres_d;
  logic [15:0]      rdaddr_q, rdaddr_d;
  logic [111:0]     rx_q, tx_q;
  logic             wq_valid, wq_ready, timeout;
  logic [47:0]      wq_data;
  logic [15:0]      w0, w1, w2;

  // Request words, upper half of each value in the lower word
  assign w0 = rx_q[mdss_pkg::W0_LSB +: 16];
  assign w1 = rx_q[mdss_pkg::W1_LSB +: 16];
  assign w2 = rx_q[mdss_pkg::W2_LSB +: 16];
  assign timeout = (wait_q == CNT_W'(mdss_pkg::WAIT_CYCLES - 1));

  always_comb begin
    st_d     = st_q;
    pend_d   = pend_q;
    is_wr_d  = is_wr_q;
    is_rd_d  = is_rd_q;
    ok0_d    = ok0_q;
    ok1_d    = ok1_q;
    rdreq_d  = 1'b0;
    wait_d   = '0;
    rdres_d  = rdres_q;
    rdaddr_d = rdaddr_q;
    wq_valid = 1'b0;
    wq_data  = {w1, rx_q[mdss_pkg::P0_LSB +: 32]};
    case (st_q)
      mdss_pkg::ST_IDLE: begin
        // Always listening, no enable needed
        if (ss_fall) begin
          st_d   = mdss_pkg::ST_RECV;
          pend_d = 1'b1;
        end
      end
      mdss_pkg::ST_RECV: begin
        if (ss_rise) begin
          if (bitcnt_q == mdss_pkg::BITS_IN_FRAME) begin
            st_d = mdss_pkg::ST_TICK;
          end else begin
            st_d   = mdss_pkg::ST_IDLE;
            pend_d = 1'b0;
          end
        end
      end
      mdss_pkg::ST_TICK: begin
        // Commit only on the update tick
        if (tick) begin
          is_wr_d = (w0 == mdss_pkg::WRITE_FLAG);
          is_rd_d = (w0 == mdss_pkg::READ_FLAG);
          ok0_d   = 1'b0;
          ok1_d   = 1'b0;
          if (w0 == mdss_pkg::WRITE_FLAG) begin
            st_d = mdss_pkg::ST_WR0;
          end else if (w0 == mdss_pkg::READ_FLAG) begin
            st_d     = mdss_pkg::ST_RD;
            rdreq_d  = 1'b1;
            rdaddr_d = w1;
          end else begin
            st_d = mdss_pkg::ST_BUILD;
          end
        end
      end
      mdss_pkg::ST_WR0: begin
        // First write waits for room, fails after the timeout
        wq_valid = 1'b1;
        wait_d   = CNT_W'(wait_q + 1'b1);
        if (wq_ready) begin
          ok0_d  = 1'b1;
          st_d   = mdss_pkg::ST_WR1;
          wait_d = '0;
        end else if (timeout) begin
          st_d   = mdss_pkg::ST_WR1;
          wait_d = '0;
        end
      end
      mdss_pkg::ST_WR1: begin
        wq_valid = 1'b1;
        wq_data  = {w2, rx_q[mdss_pkg::P1_LSB +: 32]};
        wait_d   = CNT_W'(wait_q + 1'b1);
        if (wq_ready) begin
          ok1_d = 1'b1;
          st_d  = mdss_pkg::ST_BUILD;
        end else if (timeout) begin
          st_d = mdss_pkg::ST_BUILD;
        end
      end
      mdss_pkg::ST_RD: begin
        wait_d = CNT_W'(wait_q + 1'b1);
        if (RD_ACK) begin
          rdres_d = RD_FAIL ? mdss_pkg::READ_FAILED : RD_DATA;
          st_d    = mdss_pkg::ST_BUILD;
        end else if (timeout) begin
          rdres_d = mdss_pkg::READ_FAILED;
          st_d    = mdss_pkg::ST_BUILD;
        end
      end
      mdss_pkg::ST_BUILD: begin
        st_d   = mdss_pkg::ST_IDLE;
        pend_d = 1'b0;
      end
      default: begin
        st_d   = mdss_pkg::ST_IDLE;
        pend_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_q     <= mdss_pkg::ST_IDLE;
      pend_q   <= 1'b0;
      is_wr_q  <= 1'b0;
      is_rd_q  <= 1'b0;
      ok0_q    <= 1'b0;
      ok1_q    <= 1'b0;
      rdreq_q  <= 1'b0;
      wait_q   <= '0;
      rdres_q  <= mdss_pkg::READ_FAILED;
      rdaddr_q <= 16'h0000;
    end else begin
      st_q     <= st_d;
      pend_q   <= pend_d;
      is_wr_q  <= is_wr_d;
      is_rd_q  <= is_rd_d;
      ok0_q    <= ok0_d;
      ok1_q    <= ok1_d;
      rdreq_q  <= rdreq_d;
      wait_q   <= wait_d;
      rdres_q  <= rdres_d;
      rdaddr_q <= rdaddr_d;
    end
  end

  assign FRAME_PENDING_OUT = pend_q;
  assign RD_REQ            = rdreq_q;
  assign RD_ADDR           = rdaddr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Serial shifting and response building
  logic [111:0]        rx_d, tx_d, resp, hold_q, hold_d;
  logic                miso_q, miso_d;
  logic [15:0]         r1, r2;

  always_comb begin
    // Response words 1-2 by request kind
    r1 = ok0_q ? w1 : mdss_pkg::ADDR_FAILED;
    r2 = ok1_q ? w2 : mdss_pkg::ADDR_FAILED;
    if (is_rd_q) begin
      {r1, r2} = rdres_q;
    end else if (!is_wr_q) begin
      {r1, r2} = 32'h00000000;
    end
    // Last eight bytes always pointer readbacks
    resp = {w0, r1, r2,
            PTR0_FAIL ? mdss_pkg::READ_FAILED : PTR0_DATA,
            PTR1_FAIL ? mdss_pkg::READ_FAILED : PTR1_DATA};
    bitcnt_d = bitcnt_q;
    rx_d     = rx_q;
    tx_d     = tx_q;
    hold_d   = hold_q;
    miso_d   = miso_q;
    if (st_q == mdss_pkg::ST_IDLE && ss_fall) begin
      bitcnt_d = '0;
      tx_d     = hold_q; // Reload answer, a dropped frame must not eat it
    end else if (st_q == mdss_pkg::ST_RECV) begin
      if (sclk_rise) begin
        miso_d = tx_q[111];
        tx_d   = {tx_q[110:0], 1'b0};
      end
      if (sclk_fall) begin
        rx_d     = {rx_q[110:0], mosi_q[1]};
        bitcnt_d = BITCNT_W'(bitcnt_q + 1'b1);
      end
    end else if (st_q == mdss_pkg::ST_BUILD) begin
      tx_d   = resp;
      hold_d = resp;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      bitcnt_q <= '0;
      rx_q     <= '0;
      tx_q     <= '0;
      hold_q   <= '0;
      miso_q   <= 1'b0;
    end else begin
      bitcnt_q <= bitcnt_d;
      rx_q     <= rx_d;
      tx_q     <= tx_d;
      hold_q   <= hold_d;
      miso_q   <= miso_d;
    end
  end

  assign SPI_MISO = miso_q;

  ////////////////////////////////////////////////////////////////////////////
  // Write buffer toward the register side
  mdss_fifo #(
    .WIDTH (mdss_pkg::WQ_WIDTH),
    .DEPTH (mdss_pkg::WQ_DEPTH)
  ) u_wq (
    .clk       (CORE_CLK),
    .rst_n     (RSTN),
    .in_valid  (wq_valid),
    .in_ready  (wq_ready),
    .in_data   (wq_data),
    .out_valid (WR_VALID),
    .out_ready (WR_READY),
    .out_data  ({WR_ADDR, WR_DATA})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_pend_start: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (st_q == mdss_pkg::ST_IDLE && ss_fall) |=> pend_q && st_q == mdss_pkg::ST_RECV)
    else $error("pending not raised at frame start");
  a_pend_release: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    $fell(pend_q) |-> ($past(st_q) == mdss_pkg::ST_BUILD || $past(st_q) == mdss_pkg::ST_RECV))
    else $error("pending dropped before response ready");
  a_count_resync: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (st_q == mdss_pkg::ST_IDLE && ss_fall) |=> bitcnt_q == '0)
    else $error("bit counter not reset at frame start");
  a_resp_kept: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (st_q == mdss_pkg::ST_IDLE && ss_fall) |=> tx_q == $past(hold_q))
    else $error("held answer not reloaded at frame start");
  a_frame_len: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (st_q == mdss_pkg::ST_RECV && ss_rise) |=>
      (st_q == mdss_pkg::ST_TICK) == ($past(bitcnt_q) == mdss_pkg::BITS_IN_FRAME))
    else $error("frame length check wrong");
  a_mosi_capture: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (st_q == mdss_pkg::ST_RECV && sclk_fall) |=> rx_q[0] == $past(mosi_q[1]))
    else $error("MOSI not captured on falling edge");
  a_miso_msb: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (st_q == mdss_pkg::ST_RECV && sclk_rise) |=> SPI_MISO == $past(tx_q[111]))
    else $error("MISO not MSB first on rising edge");
  a_tick_wait: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (st_q == mdss_pkg::ST_TICK && !tick) |=> st_q == mdss_pkg::ST_TICK)
    else $error("frame committed off the update tick");
  a_read_request: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (st_q == mdss_pkg::ST_TICK && tick && w0 == mdss_pkg::READ_FLAG) |=>
      RD_REQ && RD_ADDR == $past(w1) ##1 !RD_REQ)
    else $error("read request not issued once");
  a_ptr_fail: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (st_q == mdss_pkg::ST_BUILD && PTR0_FAIL) |=>
      tx_q[mdss_pkg::P0_LSB +: 32] == mdss_pkg::READ_FAILED)
    else $error("pointer failure pattern missing");
  a_write_echo: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (st_q == mdss_pkg::ST_BUILD && is_wr_q) |=>
      tx_q[mdss_pkg::W1_LSB +: 16] == ($past(ok0_q) ? $past(w1) : mdss_pkg::ADDR_FAILED))
    else $error("write address echo wrong");
endmodule

`default_nettype wire

//--- mdss_pkg.sv
// Purpose: Shared constants and types of the mirror driver SPI slave port
// Assumes: Core clock at 20 MHz, frames of fourteen bytes
// Notes:   Names are used as mdss_pkg::name, nothing is imported
package mdss_pkg;
  // Core clock and register update rate
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned UPDATE_HZ     = 10_000;
  localparam int unsigned UPDATE_CYCLES = CLK_HZ / UPDATE_HZ;
  // Longest wait for the register side, in microseconds and cycles
  localparam int unsigned WAIT_US       = 50;
  localparam int unsigned WAIT_CYCLES   = (WAIT_US * (CLK_HZ / 1_000_000));
  localparam int unsigned CNT_W         = 12;
  // Frame layout
  localparam int unsigned BYTE_BITS     = 8;
  localparam int unsigned FRAME_BYTES   = 14;
  localparam int unsigned FRAME_BITS    = FRAME_BYTES * BYTE_BITS;
  localparam int unsigned BITCNT_W      = 7;
  localparam logic [6:0]  BITS_IN_FRAME = 7'h70;
  // Word positions inside the frame shift register, word 0 at the top
  localparam int unsigned W0_LSB        = 96;
  localparam int unsigned W1_LSB        = 80;
  localparam int unsigned W2_LSB        = 64;
  localparam int unsigned P0_LSB        = 32;
  localparam int unsigned P1_LSB        = 0;
  // Flag and answer values
  localparam logic [15:0] WRITE_FLAG    = 16'h0001;
  localparam logic [15:0] READ_FLAG     = 16'h0000;
  localparam logic [15:0] ADDR_FAILED   = 16'h0000;
  localparam logic [31:0] READ_FAILED   = 32'h7cf0bdc2;
  // Buffer of pending writes
  localparam int unsigned WQ_WIDTH      = 48;
  localparam int unsigned WQ_DEPTH      = 4;
  // Frame handling states
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_RECV  = 7'h02,
    ST_TICK  = 7'h04,
    ST_WR0   = 7'h08,
    ST_WR1   = 7'h10,
    ST_RD    = 7'h20,
    ST_BUILD = 7'h40
  } mdss_state_type;
endpackage

//--- mdss_spi_master.sv
// Purpose: Behavioural SPI master acting as the far side of the slave port
// Assumes: Mode 1, link clock period of 400 ns, 250 ns high and 150 ns low
// Notes:   Clock stands low outside frames, data line shows inverse when released
`timescale 1ns/1ps
`default_nettype none
module mdss_spi_master (
  output logic      sclk,
  output logic      mosi,
  output logic      ss_n,
  input  wire logic miso
);
  ////////////////////////////////////////////////////////////////////////////////
  // Idle levels from time zero
  initial begin
    sclk = 1'b0;
    mosi = 1'b0;
    ss_n = 1'b1;
  end

  // One frame of nbits bits taken from the top of tx, answer into rx
  task automatic xfer(input logic [111:0] tx, input int nbits, output logic [111:0] rx);
    rx = '0;
    ss_n = 1'b0;
    #200;
    for (int i = 0; i < nbits; i++) begin
      sclk = 1'b1;
      mosi = tx[111-i];
      #250;
      sclk = 1'b0;
      rx[111-i] = miso;
      #150;
    end
    #200;
    ss_n = 1'b1;
    mosi = ~mosi;
  endtask
endmodule
`default_nettype wire

//--- tb_mdss_spi_slave.sv
// Purpose: Self-checking bench of the mirror driver SPI slave port
// Assumes: Core clock 50 ns, register side modelled in this module
// Notes:   Each frame's answer belongs to the frame before it
`timescale 1ns/1ps
`default_nettype none
module tb_mdss_spi_slave;
  logic        CORE_CLK, RSTN, SPI_SCLK, SPI_MOSI, SPI_SS_N, SPI_MISO;
  logic        FRAME_PENDING_OUT, WR_VALID, WR_READY, RD_REQ, RD_ACK, RD_FAIL;
  logic        PTR0_FAIL, PTR1_FAIL, rd_bad;
  logic [15:0] WR_ADDR, RD_ADDR, exp_rd_addr;
  logic [31:0] WR_DATA, RD_DATA, PTR0_DATA, PTR1_DATA, rd_val;
  logic [47:0] wq[$];
  int          fails, checked, pend_seen;
  localparam logic [31:0] PA = 32'h3d4ccccd;
  localparam logic [31:0] PB = 32'hbda3d70a;
  localparam logic [31:0] PC = 32'h40a00000;
  localparam logic [31:0] BAD = mdss_pkg::READ_FAILED;
  localparam logic [15:0] WF = mdss_pkg::WRITE_FLAG;
  localparam logic [15:0] RF = mdss_pkg::READ_FLAG;

  mdss_spi_slave mdss_spi_slave_i (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .SPI_SCLK(SPI_SCLK),
    .SPI_MOSI(SPI_MOSI), .SPI_SS_N(SPI_SS_N), .SPI_MISO(SPI_MISO),
    .FRAME_PENDING_OUT(FRAME_PENDING_OUT), .WR_VALID(WR_VALID), .WR_READY(WR_READY),
    .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA), .RD_REQ(RD_REQ), .RD_ADDR(RD_ADDR),
    .RD_ACK(RD_ACK), .RD_FAIL(RD_FAIL), .RD_DATA(RD_DATA), .PTR0_DATA(PTR0_DATA),
    .PTR0_FAIL(PTR0_FAIL), .PTR1_DATA(PTR1_DATA), .PTR1_FAIL(PTR1_FAIL));
  mdss_spi_master mdss_spi_master_i (.sclk(SPI_SCLK), .mosi(SPI_MOSI), .ss_n(SPI_SS_N),
    .miso(SPI_MISO));

  ////////////////////////////////////////////////////////////////////////////////
  // Core clock
  initial begin
    CORE_CLK = 1'b0;
    forever #25 CORE_CLK = ~CORE_CLK;
  end

  // Comparisons
  task automatic cmp_frame(input logic [111:0] got, input logic [111:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t frame got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_val48(input logic [47:0] got, input logic [47:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t value got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t flag got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Seven words, 32-bit values upper half first
  function automatic logic [111:0] fr(input logic [15:0] w0, input logic [15:0] w1,
                                      input logic [15:0] w2, input logic [31:0] d1,
                                      input logic [31:0] d2);
    return {w0, w1, w2, d1, d2};
  endfunction

  // Bounded wait until the port is ready for a frame
  task automatic wait_idle;
    int n;
    n = 0;
    while (FRAME_PENDING_OUT !== 1'b0 && n < 8000) begin
      @(negedge CORE_CLK);
      n++;
    end
    if (n >= 8000) begin
      fails++;
      $display("[FAIL] %0t pending never dropped", $time);
      print_verdict();
    end
  endtask

  // One frame, its answer checked only when all 112 bits are sent
  task automatic run_frame(input logic [111:0] tx, input int nbits, input logic [111:0] exp);
    logic [111:0] rx;
    int           p0;
    wait_idle();
    @(negedge CORE_CLK);
    p0 = pend_seen;
    mdss_spi_master_i.xfer(tx, nbits, rx);
    repeat (2) @(negedge CORE_CLK);
    cmp_bit(pend_seen > p0, 1'b1);
    wait_idle();
    if (nbits == 112) cmp_frame(rx, exp);
  endtask

  // Pending seen high while selected
  always @(posedge CORE_CLK) begin
    if (SPI_SS_N === 1'b0 && FRAME_PENDING_OUT === 1'b1) pend_seen <= pend_seen + 1;
  end

  // Buffer pops against expected entries, oldest first
  always @(posedge CORE_CLK) begin
    if (WR_VALID === 1'b1 && WR_READY === 1'b1) begin
      cmp_val48({WR_ADDR, WR_DATA}, wq.size() > 0 ? wq.pop_front() : 48'hx);
    end
  end

  // Register side answering read requests after five cycles
  initial begin
    RD_ACK = 1'b0;
    RD_FAIL = 1'b0;
    RD_DATA = 32'h0;
    forever begin
      @(posedge CORE_CLK);
      if (RD_REQ === 1'b1) begin
        cmp_val48({RD_ADDR, 32'h0}, {exp_rd_addr, 32'h0});
        repeat (5) @(negedge CORE_CLK);
        RD_ACK = 1'b1;
        RD_DATA = rd_val;
        RD_FAIL = rd_bad;
        @(negedge CORE_CLK);
        RD_ACK = 1'b0;
      end
    end
  end

  // Main sequence
  initial begin
    RSTN = 1'b0;
    WR_READY = 1'b0;
    PTR0_DATA = PA;
    PTR1_DATA = PB;
    PTR0_FAIL = 1'b0;
    PTR1_FAIL = 1'b0;
    rd_val = PC;
    rd_bad = 1'b0;
    exp_rd_addr = 16'h0;
    fails = 0;
    checked = 0;
    repeat (16) @(negedge CORE_CLK);
    RSTN = 1'b1;
    repeat (4) @(negedge CORE_CLK);
    cmp_bit(FRAME_PENDING_OUT, 1'b0);
    // Two write frames fill the buffer while the register side stalls
    wq.push_back({16'h5000, PA});
    wq.push_back({16'h5100, PB});
    run_frame(fr(WF, 16'h5000, 16'h5100, PA, PB), 112, 112'h0);
    PTR0_FAIL = 1'b1;
    wq.push_back({16'h4000, 32'h60});
    wq.push_back({16'h4005, 32'h61});
    run_frame(fr(WF, 16'h4000, 16'h4005, 32'h60, 32'h61), 112,
              fr(WF, 16'h5000, 16'h5100, PA, PB));
    PTR0_FAIL = 1'b0;
    PTR1_FAIL = 1'b1;
    // Third write frame is refused by the full buffer
    run_frame(fr(WF, 16'h6000, 16'h6100, PC, PC), 112,
              fr(WF, 16'h4000, 16'h4005, BAD, PB));
    PTR1_FAIL = 1'b0;
    WR_READY = 1'b1;
    exp_rd_addr = 16'h6002;
    run_frame(fr(RF, 16'h6002, 16'h0, 32'h0, 32'h0), 112,
              fr(WF, 16'h0, 16'h0, PA, BAD));
    exp_rd_addr = 16'h6003;
    rd_bad = 1'b1;
    run_frame(fr(RF, 16'h6003, 16'h0, 32'h0, 32'h0), 112,
              fr(RF, PC[31:16], PC[15:0], PA, PB));
    // Short frame is dropped and the previous answer kept
    run_frame(fr(RF, 16'h6003, 16'h0, 32'h0, 32'h0), 8, 112'h0);
    run_frame(fr(RF, 16'h6003, 16'h0, 32'h0, 32'h0), 112,
              fr(RF, BAD[31:16], BAD[15:0], PA, PB));
    // Unknown flag: echoed, words 1-2 zero, nothing written or read
    run_frame(fr(16'h0002, 16'h5000, 16'h5100, PA, PB), 112,
              fr(RF, BAD[31:16], BAD[15:0], PA, PB));
    run_frame(fr(16'h0002, 16'h5000, 16'h5100, PA, PB), 112,
              fr(16'h0002, 16'h0, 16'h0, PA, PB));
    repeat (20) @(negedge CORE_CLK);
    cmp_bit(WR_VALID, 1'b0);
    cmp_bit(wq.size() == 0, 1'b1);
    print_verdict();
  end
endmodule
`default_nettype wire
